// file: design/nvs_pkg.sv
package nvs_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE        = 8'h02;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_DISARM       = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_ARM_WRITES   = 8'h06;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_CLOCK_WRITE  = 8'h12;
  localparam logic [7:0] OP_CLOCK_READ   = 8'h13;
  localparam logic [7:0] OP_CLOCK_FAST   = 8'h1D;
  localparam logic [7:0] OP_STORE        = 8'h3C;
  localparam logic [7:0] OP_RECALL       = 8'h60;
  localparam logic [7:0] OP_AUTO_ON      = 8'h59;
  localparam logic [7:0] OP_AUTO_OFF     = 8'h19;

  // ==========================================================
  // status byte layout and reset values
  localparam int ST_BUSY  = 0;
  localparam int ST_WEN   = 1;
  localparam int ST_SEL0  = 2;
  localparam int ST_SEL1  = 3;
  localparam int ST_GUARD = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ==========================================================
  // clock register block
  localparam logic [3:0] RTC_FLAGS_IDX = 4'h0;
  localparam int         FLAG_SNAP     = 0;
  localparam int         FLAG_SET      = 1;
  localparam logic [1:0] FLAGS_RST     = 2'h0;

  // ==========================================================
  // protected ranges
  localparam logic [15:0] GUARD_QUARTER = 16'hC000;
  localparam logic [15:0] GUARD_HALF    = 16'h8000;

  typedef enum logic [2:0] {
    PH_CMD    = 3'b000,
    PH_ADDR   = 3'b001,
    PH_DUMMY  = 3'b010,
    PH_DATA   = 3'b011,
    PH_IGNORE = 3'b100
  } nvs_phase_e;

  typedef enum logic [2:0] {
    RES_NONE   = 3'b000,
    RES_ARM    = 3'b001,
    RES_DISARM = 3'b010,
    RES_STATUS = 3'b011,
    RES_DONE   = 3'b100
  } nvs_res_e;

  function automatic logic isGuarded(input logic [15:0] a, input logic [1:0] sel);
    case (sel)
      2'b01:   isGuarded = (a >= GUARD_QUARTER);
      2'b10:   isGuarded = (a >= GUARD_HALF);
      2'b11:   isGuarded = 1'b1;
      default: isGuarded = 1'b0;
    endcase
  endfunction

  function automatic logic isRtcOp(input logic [7:0] op);
    isRtcOp = (op == OP_CLOCK_WRITE) || (op == OP_CLOCK_READ) || (op == OP_CLOCK_FAST);
  endfunction

  function automatic logic isReadOp(input logic [7:0] op);
    isReadOp = (op == OP_READ) || (op == OP_FAST_READ) || (op == OP_STATUS_READ)
            || (op == OP_CLOCK_READ) || (op == OP_CLOCK_FAST);
  endfunction

endpackage

// file: design/nvs_sync_bits.sv
`timescale 1ns/1ps
module nvs_sync_bits #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================
  // two-stage level synchroniser
  logic [WIDTH-1:0] stage1Q;

  always_ff @(posedge clk)
  begin
    stage1Q <= d;
    q       <= stage1Q;
  end

endmodule

// file: design/nvs_cs_watch.sv
`timescale 1ns/1ps
module nvs_cs_watch (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic csN,
  input  wire logic wpN,
  output logic      csFall,
  output logic      csRise,
  output logic      wpLevel
);

  // ==========================================================
  // synchronise select and protect pins, find select edges
  logic [1:0] stage1Q;
  logic       csSyncQ;
  logic       csPrevQ;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1Q <= 2'h3;
      csSyncQ <= 1'b1;
      wpLevel <= 1'b1;
      csPrevQ <= 1'b1;
    end
    else
    begin
      stage1Q <= {csN, wpN};
      csSyncQ <= stage1Q[1];
      wpLevel <= stage1Q[0];
      csPrevQ <= csSyncQ;
    end
  end

  assign csFall = csPrevQ & ~csSyncQ;
  assign csRise = ~csPrevQ & csSyncQ;

endmodule

// file: design/nvs_spi_access.sv
`timescale 1ns/1ps
// Notes on behaviour
// - protect pin low with pin guard enabled rejects status writes
// - pin guard disabled ignores protect pin entirely
// - protect pin falling mid-frame leaves that frame's status write intact
// - array read and write refused while store or recall runs
// - read: opcode, two address bytes, data out MSB first on falling edges
// - input bits after final address bit are ignored during reads
// - read burst increments address, wraps 0xFFFF to 0x0000
// - fast read adds one dummy byte before data
// - fast read increments and wraps; select high ends it
// - array write needs latch set: opcode, two address bytes, data
// - write burst stores to incrementing addresses, wraps 0xFFFF to 0x0000
// - write latch cleared when array write completes
// - guarded addresses skipped in burst writes, address still increments
// - sixteen clock registers, burst address wraps 0x0F to 0x00
// - clock read: opcode, 8-bit address, later input ignored
// - fast clock read adds dummy byte, wraps at 0x0F
// - clock writes except flags need set bit; counters load on clear
// - store busy shown in status byte and on busy pin
// - write-type commands ignored when write latch is 0
// - guard select: 00 none, 01 top quarter, 10 top half, 11 all
// - write latch cleared after each write-type or special command
// - clock write: opcode, 8-bit address, data bytes, latch set
module nvs_spi_access (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic spiClk,
  input  wire logic csN,
  input  wire logic si,
  output logic      soOut,
  output logic      soOe,
  input  wire logic wpN,
  input  wire logic storeBusy,
  output logic      storeBusyPinN,
  output logic      writeEnableLatch,
  output logic      blockGuardSel0,
  output logic      blockGuardSel1,
  output logic      pinGuardEnable,
  output logic      rtcSnapshot,
  output logic      rtcLoadPulse
);

  // ==========================================================
  // system domain state
  logic       wenQ;
  logic [1:0] selQ;
  logic       guardQ;
  logic       busyQ;
  logic       busyPinNQ;
  logic [1:0] flagsQ;
  logic       loadPulseQ;
  logic       seenFallQ;
  logic       lockedQ;
  logic       csFall;
  logic       csRise;
  logic       wpLevel;
  logic       applyNow;

  // ==========================================================
  // link domain state
  nvs_pkg::nvs_phase_e phaseQ;
  nvs_pkg::nvs_phase_e cmdPhase;
  nvs_pkg::nvs_res_e   resKindQ;
  logic [2:0]  bitIdxQ;
  logic [6:0]  shiftQ;
  logic [7:0]  opQ;
  logic [15:0] addrQ;
  logic        addrMoreQ;
  logic        freshQ;
  logic [7:0]  resDataQ;
  logic        resFlagWrQ;
  logic [1:0]  resFlagDataQ;
  logic [7:0]  memArr [0:65535];
  logic [7:0]  rtcArr [0:15];
  logic [5:0]  linkStat;
  logic        busyL;
  logic        wenL;
  logic [1:0]  selL;
  logic        guardL;
  logic        setL;
  logic [7:0]  newByte;
  logic        byteDone;
  logic        dataByte;
  logic        rtcWrite;
  logic [7:0]  statusByte;
  logic [7:0]  readByte;

  // ==========================================================
  // pin watch in the system domain
  nvs_cs_watch uWatch (
    .clk     (clk_sys),
    .rst     (rst),
    .csN     (csN),
    .wpN     (wpN),
    .csFall  (csFall),
    .csRise  (csRise),
    .wpLevel (wpLevel)
  );

  // results of a frame are read once select is seen high again;
  // the link clock is stopped then, so its result registers hold still
  assign applyNow = csRise & seenFallQ;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      seenFallQ <= 1'b0;
    else if (csFall)
      seenFallQ <= 1'b1;
  end

  // protect decision frozen at frame start
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      lockedQ <= 1'b0;
    else if (csFall)
      lockedQ <= guardQ & ~wpLevel;
  end

  // ==========================================================
  // write enable latch
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wenQ <= nvs_pkg::STATUS_RST[nvs_pkg::ST_WEN];
    else if (applyNow)
    begin
      case (resKindQ)
        nvs_pkg::RES_ARM:    wenQ <= 1'b1;
        nvs_pkg::RES_DISARM: wenQ <= 1'b0;
        nvs_pkg::RES_STATUS: wenQ <= 1'b0;
        nvs_pkg::RES_DONE:   wenQ <= 1'b0;
        default:             wenQ <= wenQ;
      endcase
    end
  end

  // ==========================================================
  // status byte guard fields
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      guardQ <= nvs_pkg::STATUS_RST[nvs_pkg::ST_GUARD];
      selQ   <= nvs_pkg::STATUS_RST[nvs_pkg::ST_SEL1:nvs_pkg::ST_SEL0];
    end
    else if (applyNow && (resKindQ == nvs_pkg::RES_STATUS) && !lockedQ)
    begin
      guardQ <= resDataQ[nvs_pkg::ST_GUARD];
      selQ   <= resDataQ[nvs_pkg::ST_SEL1:nvs_pkg::ST_SEL0];
    end
  end

  // ==========================================================
  // store busy report
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      busyQ     <= 1'b0;
      busyPinNQ <= 1'b1;
    end
    else
    begin
      busyQ     <= storeBusy;
      busyPinNQ <= ~storeBusy;
    end
  end

  // ==========================================================
  // clock flags and counter load
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flagsQ     <= nvs_pkg::FLAGS_RST;
      loadPulseQ <= 1'b0;
    end
    else
    begin
      loadPulseQ <= applyNow && resFlagWrQ && flagsQ[nvs_pkg::FLAG_SET]
                 && !resFlagDataQ[nvs_pkg::FLAG_SET];
      if (applyNow && resFlagWrQ)
        flagsQ <= resFlagDataQ;
    end
  end

  assign writeEnableLatch = wenQ;
  assign blockGuardSel0   = selQ[0];
  assign blockGuardSel1   = selQ[1];
  assign pinGuardEnable   = guardQ;
  assign storeBusyPinN    = busyPinNQ;
  assign rtcSnapshot      = flagsQ[nvs_pkg::FLAG_SNAP];
  assign rtcLoadPulse     = loadPulseQ;

  // ==========================================================
  // status levels into the link domain
  nvs_sync_bits #(
    .WIDTH (6)
  ) uLinkSync (
    .clk (spiClk),
    .d   ({flagsQ[nvs_pkg::FLAG_SET], guardQ, selQ, wenQ, busyQ}),
    .q   (linkStat)
  );

  assign setL   = linkStat[5];
  assign guardL = linkStat[4];
  assign selL   = linkStat[3:2];
  assign wenL   = linkStat[1];
  assign busyL  = linkStat[0];

  assign newByte  = {shiftQ, si};
  assign byteDone = (bitIdxQ == 3'h7);
  assign dataByte = byteDone && (phaseQ == nvs_pkg::PH_DATA);
  assign rtcWrite = dataByte && (opQ == nvs_pkg::OP_CLOCK_WRITE);

  // ==========================================================
  // command decode
  always_comb
  begin
    case (newByte)
      nvs_pkg::OP_READ,
      nvs_pkg::OP_FAST_READ:
        cmdPhase = busyL ? nvs_pkg::PH_IGNORE : nvs_pkg::PH_ADDR;
      nvs_pkg::OP_WRITE:
        cmdPhase = (busyL || !wenL) ? nvs_pkg::PH_IGNORE : nvs_pkg::PH_ADDR;
      nvs_pkg::OP_CLOCK_READ,
      nvs_pkg::OP_CLOCK_FAST:
        cmdPhase = nvs_pkg::PH_ADDR;
      nvs_pkg::OP_CLOCK_WRITE:
        cmdPhase = wenL ? nvs_pkg::PH_ADDR : nvs_pkg::PH_IGNORE;
      nvs_pkg::OP_STATUS_READ:
        cmdPhase = nvs_pkg::PH_DATA;
      nvs_pkg::OP_STATUS_WRITE:
        cmdPhase = wenL ? nvs_pkg::PH_DATA : nvs_pkg::PH_IGNORE;
      default:
        cmdPhase = nvs_pkg::PH_IGNORE;
    endcase
  end

  // ==========================================================
  // frame sequencer, cleared while select is high
  always_ff @(posedge spiClk or posedge csN)
  begin
    if (csN)
      freshQ <= 1'b1;
    else
      freshQ <= 1'b0;
  end

  always_ff @(posedge spiClk or posedge csN)
  begin
    if (csN)
    begin
      phaseQ    <= nvs_pkg::PH_CMD;
      bitIdxQ   <= 3'h0;
      shiftQ    <= 7'h00;
      opQ       <= 8'h00;
      addrQ     <= 16'h0000;
      addrMoreQ <= 1'b0;
    end
    else
    begin
      bitIdxQ <= bitIdxQ + 3'h1;
      shiftQ  <= newByte[6:0];
      if (byteDone)
      begin
        case (phaseQ)
          nvs_pkg::PH_CMD:
          begin
            opQ       <= newByte;
            phaseQ    <= cmdPhase;
            addrMoreQ <= !nvs_pkg::isRtcOp(newByte);
          end
          nvs_pkg::PH_ADDR:
          begin
            addrQ     <= {addrQ[7:0], newByte};
            addrMoreQ <= 1'b0;
            if (!addrMoreQ)
            begin
              if ((opQ == nvs_pkg::OP_FAST_READ) || (opQ == nvs_pkg::OP_CLOCK_FAST))
                phaseQ <= nvs_pkg::PH_DUMMY;
              else
                phaseQ <= nvs_pkg::PH_DATA;
            end
          end
          nvs_pkg::PH_DUMMY:
            phaseQ <= nvs_pkg::PH_DATA;
          nvs_pkg::PH_DATA:
          begin
            if (opQ == nvs_pkg::OP_STATUS_WRITE)
              phaseQ <= nvs_pkg::PH_IGNORE;
            else if (nvs_pkg::isRtcOp(opQ))
              addrQ <= {12'h000, addrQ[3:0] + 4'h1};
            else if (opQ != nvs_pkg::OP_STATUS_READ)
              addrQ <= addrQ + 16'h0001;
          end
          default:
            phaseQ <= phaseQ;
        endcase
      end
    end
  end

  // ==========================================================
  // frame results for the system domain
  always_ff @(posedge spiClk)
  begin
    if (freshQ)
    begin
      resKindQ   <= nvs_pkg::RES_NONE;
      resFlagWrQ <= 1'b0;
    end
    else if (byteDone)
    begin
      if (phaseQ == nvs_pkg::PH_CMD)
      begin
        case (newByte)
          nvs_pkg::OP_ARM_WRITES:
            resKindQ <= nvs_pkg::RES_ARM;
          nvs_pkg::OP_DISARM:
            resKindQ <= nvs_pkg::RES_DISARM;
          nvs_pkg::OP_WRITE,
          nvs_pkg::OP_CLOCK_WRITE,
          nvs_pkg::OP_STORE,
          nvs_pkg::OP_RECALL,
          nvs_pkg::OP_AUTO_ON,
          nvs_pkg::OP_AUTO_OFF:
            if (wenL)
              resKindQ <= nvs_pkg::RES_DONE;
          default:
            resKindQ <= resKindQ;
        endcase
      end
      if (dataByte && (opQ == nvs_pkg::OP_STATUS_WRITE))
      begin
        resKindQ <= nvs_pkg::RES_STATUS;
        resDataQ <= newByte;
      end
      if (rtcWrite && (addrQ[3:0] == nvs_pkg::RTC_FLAGS_IDX))
      begin
        resFlagWrQ   <= 1'b1;
        resFlagDataQ <= newByte[1:0];
      end
    end
  end

  // ==========================================================
  // memory array and clock registers
  always_ff @(posedge spiClk)
  begin
    if (dataByte && (opQ == nvs_pkg::OP_WRITE) && !nvs_pkg::isGuarded(addrQ, selL))
      memArr[addrQ] <= newByte;
  end

  always_ff @(posedge spiClk)
  begin
    if (rtcWrite && ((addrQ[3:0] == nvs_pkg::RTC_FLAGS_IDX) || setL))
      rtcArr[addrQ[3:0]] <= newByte;
  end

  // ==========================================================
  // read data selection
  always_comb
  begin
    statusByte                    = nvs_pkg::STATUS_RST;
    statusByte[nvs_pkg::ST_GUARD] = guardL;
    statusByte[nvs_pkg::ST_SEL1]  = selL[1];
    statusByte[nvs_pkg::ST_SEL0]  = selL[0];
    statusByte[nvs_pkg::ST_WEN]   = wenL;
    statusByte[nvs_pkg::ST_BUSY]  = busyL;
  end

  always_comb
  begin
    if (opQ == nvs_pkg::OP_STATUS_READ)
      readByte = statusByte;
    else if (nvs_pkg::isRtcOp(opQ))
      readByte = rtcArr[addrQ[3:0]];
    else
      readByte = memArr[addrQ];
  end

  // ==========================================================
  // serial output on falling edges, off while select is high
  always_ff @(negedge spiClk or posedge csN)
  begin
    if (csN)
    begin
      soOe  <= 1'b0;
      soOut <= 1'b0;
    end
    else if ((phaseQ == nvs_pkg::PH_DATA) && nvs_pkg::isReadOp(opQ))
    begin
      soOe  <= 1'b1;
      soOut <= readByte[3'h7 - bitIdxQ];
    end
    else
    begin
      soOe  <= 1'b0;
      soOut <= 1'b0;
    end
  end

endmodule

// file: sim/nvs_spi_access_asserts.sv
`timescale 1ns/1ps
module nvs_spi_access_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic si,
  input wire logic soOut,
  input wire logic soOe,
  input wire logic wpN,
  input wire logic storeBusy,
  input wire logic storeBusyPinN,
  input wire logic writeEnableLatch,
  input wire logic blockGuardSel0,
  input wire logic blockGuardSel1,
  input wire logic pinGuardEnable,
  input wire logic rtcSnapshot,
  input wire logic rtcLoadPulse
);
  // ==========
  // frame lock tracking
  logic       csSeen_q;
  logic [2:0] wpLow_q;
  logic       lock_q;
  always_ff @(posedge clk_sys)
    csSeen_q <= csN;
  always_ff @(posedge clk_sys)
    if (rst || wpN)
      wpLow_q <= 3'h0;
    else if (wpLow_q != 3'h7)
      wpLow_q <= wpLow_q + 3'h1;
  // lock decided at select fall, so a pin drop mid-frame does not count
  always_ff @(posedge clk_sys)
    if (rst)
      lock_q <= 1'b0;
    else if (csSeen_q && !csN)
      lock_q <= pinGuardEnable && (wpLow_q == 3'h7);
  // ==========
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_busy_pin: assert property (1'b1 |=> storeBusyPinN != $past(storeBusy))
    else $error("busy pin does not follow store busy");
  a_oe_idle: assert property (csN |-> !soOe)
    else $error("serial out driven while deselected");
  a_pulse_single: assert property (rtcLoadPulse |=> !rtcLoadPulse)
    else $error("load pulse longer than one cycle");
  a_pulse_idle: assert property (rtcLoadPulse |-> csN && $past(csN))
    else $error("load pulse inside a frame");
  a_latch_idle: assert property (!$stable(writeEnableLatch) |-> csN && $past(csN))
    else $error("write latch changed inside a frame");
  a_guard_idle: assert property
    (!$stable({pinGuardEnable, blockGuardSel1, blockGuardSel0}) |-> csN)
    else $error("status bits changed inside a frame");
  a_wp_lock: assert property
    (lock_q |-> $stable({pinGuardEnable, blockGuardSel1, blockGuardSel0}))
    else $error("status changed while pin guard locked");
  a_snap_idle: assert property (!$stable(rtcSnapshot) |-> csN)
    else $error("snapshot bit changed inside a frame");
  a_reset_vals: assert property ($fell(rst) |-> !writeEnableLatch && !pinGuardEnable
    && !blockGuardSel0 && !blockGuardSel1 && storeBusyPinN && !rtcSnapshot)
    else $error("wrong state after reset");
endmodule

bind nvs_spi_access nvs_spi_access_asserts chk_u (.clk_sys, .rst, .spiClk, .csN, .si,
  .soOut, .soOe, .wpN, .storeBusy, .storeBusyPinN, .writeEnableLatch, .blockGuardSel0,
  .blockGuardSel1, .pinGuardEnable, .rtcSnapshot, .rtcLoadPulse);

// file: sim/nvs_spi_host.sv
`timescale 1ns/1ps
module nvs_spi_host (
  output logic      spiClk,
  output logic      csN,
  output logic      si,
  input  wire logic soOut,
  input  wire logic soOe
);
  logic [7:0] txb [8];
  logic [7:0] rxb [8];
  logic       oeSeen;
  initial
  begin
    spiClk = 1'b0;
    si = 1'b0;
    // a real rising edge on select clears the link logic before any frame
    #1 csN = 1'b1;
  end
  // ==========
  // one frame, mode 0, 160 ns link period, clock still between frames
  task automatic frame(input int n);
    oeSeen = 1'b0;
    csN = 1'b0;
    #103;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
      begin
        si = txb[i][b];
        #80 spiClk = 1'b1;
        rxb[i][b] = soOut;
        if (soOe === 1'b1)
          oeSeen = 1'b1;
        #80 spiClk = 1'b0;
      end
    #80 csN = 1'b1;
    // stale input bit is not left on the line
    si = ~si;
    #300;
  endtask
endmodule

// file: sim/nvs_spi_access_bench.sv
`timescale 1ns/1ps
module nvs_spi_access_bench;
  localparam logic [7:0] WR = nvs_pkg::OP_WRITE;
  localparam logic [7:0] RD = nvs_pkg::OP_READ;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wpN = 1'b1;
  logic storeBusy = 1'b0;
  logic spiClk, csN, si, soOut, soOe, storeBusyPinN, writeEnableLatch;
  logic blockGuardSel0, blockGuardSel1, pinGuardEnable, rtcSnapshot, rtcLoadPulse;
  int   n_errors = 0;
  int   samples_checked = 0;
  int   nLoads = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (rtcLoadPulse === 1'b1)
      nLoads <= nLoads + 1;
  nvs_spi_access dut_u (.clk_sys, .rst, .spiClk, .csN, .si, .soOut, .soOe, .wpN,
    .storeBusy, .storeBusyPinN, .writeEnableLatch, .blockGuardSel0, .blockGuardSel1,
    .pinGuardEnable, .rtcSnapshot, .rtcLoadPulse);
  nvs_spi_host host_u (.spiClk, .csN, .si, .soOut, .soOe);
  // ==========
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input int n, input logic [63:0] v);
    @(negedge clk_sys);
    for (int i = 0; i < n; i++)
      host_u.txb[i] = v[63-8*i -: 8];
    host_u.frame(n);
  endtask
  task automatic arm();
    send(1, {nvs_pkg::OP_ARM_WRITES, 56'h0});
  endtask
  task automatic setStatus(input logic [7:0] v);
    arm();
    send(2, {nvs_pkg::OP_STATUS_WRITE, v, 48'h0});
  endtask
  task automatic setWp(input logic v);
    @(negedge clk_sys) wpN = v;
  endtask
  function automatic logic [7:0] sts();
    // same layout as the status byte, busy bit left at zero
    return {pinGuardEnable, 3'h0, blockGuardSel1, blockGuardSel0, writeEnableLatch, 1'b0};
  endfunction
  // ==========
  // scenarios
  task automatic t_reset();
    chk({1'b0, writeEnableLatch, blockGuardSel0, blockGuardSel1, pinGuardEnable,
      rtcSnapshot, soOe, storeBusyPinN}, 8'h01, "reset state");
    $display("t_reset done");
  endtask
  task automatic t_guard();
    logic [15:0] ad [6] = '{16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000, 16'hFFFF, 16'h0000};
    logic [7:0]  ex [6];
    for (int s = 0; s < 4; s++)
    begin
      setStatus({4'h0, s[1:0], 2'b00});
      chk(sts(), {4'h0, s[1:0], 2'b00}, "guard select");
      for (int k = 0; k < 6; k += 2)
      begin
        arm();
        send(5, {WR, ad[k], s[3:0], k[3:0], s[3:0], k[3:0] + 4'h1, 24'h0});
      end
      for (int k = 0; k < 6; k++)
        if (!(s == 3 || (s == 2 && ad[k][15]) || (s == 1 && ad[k][15:14] == 2'b11)))
          ex[k] = {s[3:0], k[3:0]};
      for (int k = 0; k < 6; k += 2)
      begin
        send(5, {RD, ad[k], 40'h0});
        chk(host_u.rxb[3], ex[k], "burst byte");
        chk(host_u.rxb[4], ex[k+1], "burst next");
      end
    end
    setStatus(8'h00);
    $display("t_guard done");
  endtask
  task automatic t_array();
    arm();
    chk(sts(), 8'h02, "armed");
    send(4, {WR, 16'h1234, 8'hC3, 32'h0});
    chk(sts(), 8'h00, "after write");
    send(4, {WR, 16'h1234, 8'h3C, 32'h0});
    send(4, {RD, 16'h1234, 8'hFF, 32'h0});
    chk(host_u.rxb[3], 8'hC3, "read");
    send(6, {nvs_pkg::OP_FAST_READ, 16'hFFFF, 8'hFF, 32'h0});
    chk(host_u.rxb[4], 8'h04, "fast read");
    chk(host_u.rxb[5], 8'h25, "fast wrap");
    @(negedge clk_sys) storeBusy = 1'b1;
    send(4, {RD, 16'h1234, 40'h0});
    chk({7'h0, host_u.oeSeen}, 8'h00, "read while busy");
    chk({7'h0, storeBusyPinN}, 8'h00, "busy pin");
    send(2, {nvs_pkg::OP_STATUS_READ, 56'h0});
    chk(host_u.rxb[1], 8'h01, "busy status");
    @(negedge clk_sys) storeBusy = 1'b0;
    $display("t_array done");
  endtask
  task automatic t_wp();
    setStatus(8'h80);
    setWp(1'b0);
    setStatus(8'h8C);
    chk(sts(), 8'h80, "pin locked");
    setWp(1'b1);
    arm();
    fork
      send(2, {nvs_pkg::OP_STATUS_WRITE, 8'h84, 48'h0});
      begin
        #600;
        setWp(1'b0);
      end
    join
    chk(sts(), 8'h84, "pin drop mid frame");
    setWp(1'b1);
    setStatus(8'h00);
    setWp(1'b0);
    setStatus(8'h08);
    chk(sts(), 8'h08, "pin ignored");
    setWp(1'b1);
    setStatus(8'h00);
    $display("t_wp done");
  endtask
  task automatic t_clock();
    int n0;
    arm();
    send(3, {nvs_pkg::OP_CLOCK_WRITE, 8'h00, 8'h02, 40'h0});
    arm();
    send(5, {nvs_pkg::OP_CLOCK_WRITE, 8'h0F, 8'hAB, 8'h02, 8'h5A, 24'h0});
    send(5, {nvs_pkg::OP_CLOCK_READ, 8'h0F, 8'hFF, 40'h0});
    chk(host_u.rxb[2], 8'hAB, "clock read");
    chk(host_u.rxb[4], 8'h5A, "clock wrap");
    send(4, {nvs_pkg::OP_CLOCK_FAST, 8'h01, 48'h0});
    chk(host_u.rxb[3], 8'h5A, "clock fast read");
    n0 = nLoads;
    arm();
    send(3, {nvs_pkg::OP_CLOCK_WRITE, 8'h00, 8'h01, 40'h0});
    chk(8'(nLoads - n0), 8'h01, "load pulses");
    chk({7'h0, rtcSnapshot}, 8'h01, "snapshot");
    arm();
    send(3, {nvs_pkg::OP_CLOCK_WRITE, 8'h01, 8'h77, 40'h0});
    send(3, {nvs_pkg::OP_CLOCK_READ, 8'h01, 48'h0});
    chk(host_u.rxb[2], 8'h5A, "write without set bit");
    $display("t_clock done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_guard();
    t_array();
    t_wp();
    t_clock();
    close_out();
  end
  initial
  begin
    #900000;
    n_errors++;
    close_out();
  end
endmodule
